//--- verilog/lpwm_cfg.svh
// Constants of the 18-channel LED PWM block: register map, command values, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LPWM_CFG_SVH
`define LPWM_CFG_SVH

`define LPWM_NCH 18
`define LPWM_CH_W 5
`define LPWM_REG_SSD 8'h00
`define LPWM_REG_DUTY0 8'h01
`define LPWM_REG_DUTYN 8'h12
`define LPWM_REG_UPD 8'h13
`define LPWM_REG_SCL0 8'h14
`define LPWM_REG_SCLN 8'h25
`define LPWM_REG_GCTL 8'h26
`define LPWM_REG_FREQ 8'h27
`define LPWM_REG_RST 8'h2F
`define LPWM_CMD_VAL 8'h00
`define LPWM_RST_BIT 1'h0
`define LPWM_RST_BYTE 8'h00
`define LPWM_RST_SCALE 6'h00

`define LPWM_DEV_ID_HI 5'h1B
`define LPWM_RW_WRITE 1'h0
`define LPWM_BYTE_BITS 4'h8

`define LPWM_CLK_HZ 125000000
`define LPWM_PWM_STEPS 256
`define LPWM_FAST_HZ 29000
`define LPWM_SLOW_HZ 4000
`define LPWM_FAST_DIV (`LPWM_CLK_HZ / (`LPWM_FAST_HZ * `LPWM_PWM_STEPS))
`define LPWM_SLOW_DIV (`LPWM_CLK_HZ / (`LPWM_SLOW_HZ * `LPWM_PWM_STEPS))

`define LPWM_SC_FULL 6'h30
`define LPWM_SC_23 6'h31
`define LPWM_SC_22 6'h35
`define LPWM_SC_21 6'h32
`define LPWM_SC_20 6'h36
`define LPWM_SC_19 6'h33
`define LPWM_SC_18 6'h3A
`define LPWM_SC_16 6'h3B
`define LPWM_SC_14 6'h3F
`define LPWM_SC_12 6'h10
`define LPWM_SC_11 6'h11
`define LPWM_SC_9 6'h12
`define LPWM_SC_7 6'h13

`endif

//--- verilog/lpwm_pkg.sv
// Types and the current-scale decoder of the LED PWM block.
// Assumes lpwm_cfg.svh on the include path.
`include "lpwm_cfg.svh"

package lpwm_pkg;

  typedef logic [`LPWM_NCH-1:0][7:0] lpwm_duty_arr_t;
  typedef logic [`LPWM_NCH-1:0][5:0] lpwm_scale_arr_t;
  typedef logic [`LPWM_NCH-1:0][4:0] lpwm_num_arr_t;

  typedef enum logic [2:0] {st_idle, st_devaddr, st_regaddr, st_data, st_skip} lpwm_i2c_st_t;

  typedef struct packed {
    logic [1:0] rs;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] ad_s1;
    logic [1:0] ad_s2;
    lpwm_i2c_st_t st;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic in_ack;
    logic [7:0] ptr;
    logic tgl;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic sda_oe_n;
  } lpwm_i2c_state_t;

  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] cnt;
    logic [`LPWM_NCH-1:0] out;
  } lpwm_core_state_t;

  typedef struct packed {
    logic [2:0] tg;
    logic [1:0] hs;
    logic soft_shutdown_n;
    logic gdis;
    logic freq;
    lpwm_duty_arr_t duty_tmp;
    lpwm_scale_arr_t scale_tmp;
    lpwm_duty_arr_t duty_act;
    lpwm_scale_arr_t scale_act;
    logic [`LPWM_NCH-1:0] led;
    lpwm_num_arr_t num;
  } lpwm_top_state_t;

  // Numerator over 24 of the maximum current; unlisted codes give a numerator of 0
  function automatic logic [4:0] lpwm_scale_num(input logic [5:0] code);
    logic [4:0] n;
    n = 5'h00;
    case (code)
      `LPWM_SC_FULL: n = 5'h18;
      `LPWM_SC_23: n = 5'h17;
      `LPWM_SC_22: n = 5'h16;
      `LPWM_SC_21: n = 5'h15;
      `LPWM_SC_20: n = 5'h14;
      `LPWM_SC_19: n = 5'h13;
      `LPWM_SC_18: n = 5'h12;
      `LPWM_SC_16: n = 5'h10;
      `LPWM_SC_14: n = 5'h0E;
      `LPWM_SC_12: n = 5'h0C;
      `LPWM_SC_11: n = 5'h0B;
      `LPWM_SC_9: n = 5'h09;
      `LPWM_SC_7: n = 5'h07;
      default: n = 5'h00;
    endcase
    return n;
  endfunction

endpackage

//--- verilog/lpwm_wr_if.sv
// Carrier of received register writes from the link domain to the core domain.
// Assumes the source holds addr and data stable from one toggle to the next.
`timescale 1ns/1ps
`default_nettype none

interface lpwm_wr_if;
  logic tgl;
  logic [7:0] addr;
  logic [7:0] data;
  modport src (output tgl, output addr, output data);
  modport dst (input tgl, input addr, input data);
endinterface

`default_nettype wire

//--- verilog/lpwm_i2c_rx.sv
// Write-only two-wire slave receiver on the link clock.
// Assumes link_clk runs free and oversamples the bus pins; sys_rst comes from the core domain.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_cfg.svh"

module lpwm_i2c_rx (
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] addr_strap,
  output logic sda_o,
  output logic sda_oe_n,
  lpwm_wr_if.src wr
);
  import lpwm_pkg::*;

  lpwm_i2c_state_t q, d;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
  assign bus_start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
  assign bus_stop = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];

  always_comb begin
    d = q;
    d.rs = {q.rs[0], sys_rst};
    d.scl_s = {q.scl_s[1:0], scl_i};
    d.sda_s = {q.sda_s[1:0], sda_i};
    d.ad_s1 = addr_strap;
    d.ad_s2 = q.ad_s1;
    if (bus_start) begin
      d.st = st_devaddr;
      d.bitcnt = 4'h0;
      d.in_ack = 1'b0;
      d.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      d.st = st_idle;
      d.in_ack = 1'b0;
      d.sda_oe_n = 1'b1;
    end else if (q.st != st_idle && q.st != st_skip) begin
      if (scl_rise && !q.in_ack && q.bitcnt < `LPWM_BYTE_BITS) begin
        d.sh = {q.sh[6:0], q.sda_s[1]};
        d.bitcnt = q.bitcnt + 4'h1;
      end else if (scl_fall && q.in_ack) begin
        d.in_ack = 1'b0;
        d.sda_oe_n = 1'b1;
        d.bitcnt = 4'h0;
      end else if (scl_fall && q.bitcnt == `LPWM_BYTE_BITS) begin
        d.in_ack = 1'b1;
        d.sda_oe_n = 1'b0;
        case (q.st)
          st_devaddr: begin
            if (q.sh != {`LPWM_DEV_ID_HI, q.ad_s2, `LPWM_RW_WRITE}) begin
              d.st = st_skip;
              d.in_ack = 1'b0;
              d.sda_oe_n = 1'b1;
            end else begin
              d.st = st_regaddr;
            end
          end
          st_regaddr: begin
            d.ptr = q.sh;
            d.st = st_data;
          end
          st_data: begin
            // Every data byte is acknowledged, mapped or not
            d.tgl = ~q.tgl;
            d.waddr = q.ptr;
            d.wdata = q.sh;
            // Advanced here so the register byte's ack never moves the pointer
            d.ptr = q.ptr + 8'h01;
          end
          default: begin
            d.in_ack = 1'b0;
            d.sda_oe_n = 1'b1;
          end
        endcase
      end
    end
    if (q.rs[1]) begin
      d.st = st_idle;
      d.bitcnt = 4'h0;
      d.in_ack = 1'b0;
      d.sda_oe_n = 1'b1;
      d.ptr = 8'h00;
      d.tgl = 1'b0;
      d.waddr = 8'h00;
      d.wdata = 8'h00;
      d.sh = 8'h00;
    end
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = q.sda_oe_n;
  assign wr.tgl = q.tgl;
  assign wr.addr = q.waddr;
  assign wr.data = q.wdata;

endmodule

`default_nettype wire

//--- verilog/lpwm_pwm_core.sv
// Shared PWM timebase and per-channel duty compare.
// Assumes duty and enable come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_cfg.svh"

module lpwm_pwm_core (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic freq_sel,
  input wire lpwm_pkg::lpwm_duty_arr_t duty,
  input wire logic [`LPWM_NCH-1:0] ch_en,
  output logic [`LPWM_NCH-1:0] pwm_out
);
  import lpwm_pkg::*;

  lpwm_core_state_t q, d;
  logic [7:0] step_div;

  assign step_div = freq_sel ? 8'(`LPWM_SLOW_DIV - 1) : 8'(`LPWM_FAST_DIV - 1);

  always_comb begin
    d = q;
    // One counter for all channels keeps every rising edge aligned
    if (q.pre >= step_div) begin
      d.pre = 8'h00;
      d.cnt = q.cnt + 8'h01;
    end else begin
      d.pre = q.pre + 8'h01;
    end
    for (int i = 0; i < `LPWM_NCH; i++) begin
      d.out[i] = ch_en[i] & (q.cnt < duty[i]);
    end
    if (sys_rst) begin
      d.pre = 8'h00;
      d.cnt = 8'h00;
      d.out = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign pwm_out = q.out;

endmodule

`default_nettype wire

//--- verilog/lpwm_top.sv
// Top of the 18-channel LED PWM block: write-only register bank, update and reset commands, gating.
// Assumes bus pins and strap on the link clock domain and the shutdown pin asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_cfg.svh"

module lpwm_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [1:0] addr_strap,
  input wire logic hw_shutdown_n,
  output logic [`LPWM_NCH-1:0] led_outputs,
  output lpwm_pkg::lpwm_num_arr_t max_current_frac
);
  import lpwm_pkg::*;

  lpwm_top_state_t q, d;
  lpwm_wr_if wr_bus ();
  logic wr_evt;
  logic [`LPWM_NCH-1:0] ch_en;
  logic [`LPWM_NCH-1:0] pwm_raw;
  logic [`LPWM_CH_W-1:0] duty_idx;
  logic [`LPWM_CH_W-1:0] scale_idx;

  lpwm_i2c_rx u_rx (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .addr_strap(addr_strap),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .wr(wr_bus)
  );

  lpwm_pwm_core u_core (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .freq_sel(q.freq),
    .duty(q.duty_act),
    .ch_en(ch_en),
    .pwm_out(pwm_raw)
  );

  // Link data is held for a whole byte time, far longer than the toggle sync delay
  assign wr_evt = q.tg[2] ^ q.tg[1];
  assign duty_idx = `LPWM_CH_W'(wr_bus.addr - `LPWM_REG_DUTY0);
  assign scale_idx = `LPWM_CH_W'(wr_bus.addr - `LPWM_REG_SCL0);

  generate
    for (genvar g = 0; g < `LPWM_NCH; g++) begin : g_en
      // Gating only; stored values stay untouched in either shutdown
      assign ch_en[g] = q.soft_shutdown_n & ~q.gdis & q.hs[1] & (q.scale_act[g][5:4] != 2'h0);
    end
  endgenerate

  always_comb begin
    d = q;
    d.tg = {q.tg[1:0], wr_bus.tgl};
    d.hs = {q.hs[0], hw_shutdown_n};
    if (wr_evt) begin
      if (wr_bus.addr == `LPWM_REG_SSD) begin
        d.soft_shutdown_n = wr_bus.data[0];
      end else if (wr_bus.addr >= `LPWM_REG_DUTY0 && wr_bus.addr <= `LPWM_REG_DUTYN) begin
        d.duty_tmp[duty_idx] = wr_bus.data;
      end else if (wr_bus.addr == `LPWM_REG_UPD) begin
        if (wr_bus.data == `LPWM_CMD_VAL) begin
          d.duty_act = q.duty_tmp;
          d.scale_act = q.scale_tmp;
        end
      end else if (wr_bus.addr >= `LPWM_REG_SCL0 && wr_bus.addr <= `LPWM_REG_SCLN) begin
        d.scale_tmp[scale_idx] = wr_bus.data[5:0];
      end else if (wr_bus.addr == `LPWM_REG_GCTL) begin
        d.gdis = wr_bus.data[0];
      end else if (wr_bus.addr == `LPWM_REG_FREQ) begin
        d.freq = wr_bus.data[0];
      end
    end
    d.led = pwm_raw;
    for (int i = 0; i < `LPWM_NCH; i++) begin
      d.num[i] = lpwm_scale_num(q.scale_act[i]);
    end
    // Sync flops are left running so a pending link toggle is not mistaken for a write
    if (sys_rst || (wr_evt && wr_bus.addr == `LPWM_REG_RST && wr_bus.data == `LPWM_CMD_VAL)) begin
      d.soft_shutdown_n = `LPWM_RST_BIT;
      d.gdis = `LPWM_RST_BIT;
      d.freq = `LPWM_RST_BIT;
      d.duty_tmp = {`LPWM_NCH{`LPWM_RST_BYTE}};
      d.duty_act = {`LPWM_NCH{`LPWM_RST_BYTE}};
      d.scale_tmp = {`LPWM_NCH{`LPWM_RST_SCALE}};
      d.scale_act = {`LPWM_NCH{`LPWM_RST_SCALE}};
      d.led = '0;
      d.num = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign led_outputs = q.led;
  assign max_current_frac = q.num;

endmodule

`default_nettype wire

//--- dv/lpwm_top_sva.sv
// Port checker of the LED PWM top.
// Assumes a bind onto lpwm_top.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_cfg.svh"
module lpwm_top_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic [1:0] addr_strap,
  input wire logic hw_shutdown_n,
  input wire logic [`LPWM_NCH-1:0] led_outputs,
  input wire lpwm_pkg::lpwm_num_arr_t max_current_frac
);
  logic frac_ok;
  always_comb begin
    frac_ok = 1'b1;
    for (int i = 0; i < `LPWM_NCH; i++)
      if (!(max_current_frac[i] inside {5'h00, 5'h07, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h10, [5'h12:5'h18]}))
        frac_ok = 1'b0;
  end
  // Allows for the pin synchroniser and output register
  sequence hw_low;
    !hw_shutdown_n [*6];
  endsequence
  sequence ack_hold;
    !sda_oe_n [*8] ##[1:40] sda_oe_n;
  endsequence
  a_sda_low: assert property (@(posedge link_clk) disable iff (sys_rst) sda_o == 1'b0)
    else $error("sda_o driven high");
  a_ack_edge: assert property (@(posedge link_clk) disable iff (sys_rst) $changed(sda_oe_n) |-> !scl_i)
    else $error("ack moved while scl high");
  a_ack_hold: assert property (@(posedge link_clk) disable iff (sys_rst) $fell(sda_oe_n) |-> ack_hold)
    else $error("ack length wrong");
  a_hw_dark: assert property (@(posedge ref_clk) disable iff (sys_rst) hw_low |-> led_outputs == 0)
    else $error("led on in hw shutdown");
  a_rst_dark: assert property (@(posedge ref_clk) sys_rst |=> led_outputs == 0)
    else $error("led on after reset");
  a_rst_frac: assert property (@(posedge ref_clk) sys_rst |=> max_current_frac == 0)
    else $error("scale not cleared by reset");
  a_start_dark: assert property (@(posedge ref_clk) $fell(sys_rst) |-> (led_outputs == 0) [*8])
    else $error("led on at start");
  a_frac_legal: assert property (@(posedge ref_clk) disable iff (sys_rst) frac_ok)
    else $error("illegal scale fraction");
endmodule
`default_nettype wire

//--- dv/lpwm_i2c_host.sv
// Two-wire bus master model issuing write transfers.
// Assumes SDA is resolved outside with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module lpwm_i2c_host (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // Phases of 5 link cycles, above the receiver minimum of 4
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= (i == 0) ? 1'b1 : b[i-1];
      tk(2);
      scl <= 1'b1;
      tk(3);
      if (i == 0) ack = !sda;
      tk(2);
      scl <= 1'b0;
      tk(3);
    end
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] q[$], output logic ok);
    logic a;
    sda_drv <= 1'b0;
    tk(5);
    scl <= 1'b0;
    tk(3);
    put(dev, ok);
    foreach (q[i]) if (ok) begin
      put(q[i], a);
      ok &= a;
    end
    sda_drv <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(5);
    sda_drv <= 1'b1;
    tk(5);
  endtask
endmodule
`default_nettype wire

//--- dv/lpwm_top_tb.sv
// Self-checking bench of the LED PWM block.
// Assumes the host model and port checker beside it.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_cfg.svh"
module lpwm_top_tb;
  import lpwm_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hw_shutdown_n = 1'b1;
  logic [1:0] strap = 2'h0;
  logic scl, sda_drv, sda_o, sda_oe_n;
  logic [`LPWM_NCH-1:0] led;
  lpwm_num_arr_t frac;
  wire sda = sda_drv & (sda_oe_n | sda_o);
  int num_errors = 0;
  int samples_checked = 0;
  int tn = 0;
  int soft_shutdown_n, gdis, frq;
  int tdu[18], tsc[18], adu[18], asc[18];
  int cd[13] = '{6'h30, 6'h31, 6'h35, 6'h32, 6'h36, 6'h33, 6'h3A, 6'h3B, 6'h3F, 6'h10, 6'h11, 6'h12, 6'h13};
  int nm[13] = '{24, 23, 22, 21, 20, 19, 18, 16, 14, 12, 11, 9, 7};
  always #4 ref_clk = ~ref_clk;
  initial #3 forever #32 link_clk = ~link_clk;
  lpwm_top u_lpwm_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_strap(strap), .hw_shutdown_n(hw_shutdown_n),
    .led_outputs(led), .max_current_frac(frac));
  lpwm_i2c_host u_lpwm_i2c_host (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask
  function automatic void mdl(input int a, input int d);
    if (a == 0) soft_shutdown_n = d & 1;
    else if (a <= 8'h12) tdu[a-1] = d;
    else if (a == 8'h13) begin
      if (d == 0) begin
        adu = tdu;
        asc = tsc;
      end
    end else if (a <= 8'h25) tsc[a-8'h14] = d & 8'h3F;
    else if (a == 8'h26) gdis = d & 1;
    else if (a == 8'h27) frq = d & 1;
    else if (a == 8'h2F && d == 0) begin
      foreach (tdu[i]) {tdu[i], tsc[i], adu[i], asc[i]} = 0;
      {soft_shutdown_n, gdis, frq} = 0;
    end
  endfunction
  function automatic int num(input int c);
    foreach (cd[i]) if (cd[i] == c) return nm[i];
    return 0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] q[$]);
    logic ok;
    logic [7:0] t[$];
    t = {a, q};
    u_lpwm_i2c_host.wr({`LPWM_DEV_ID_HI, strap, 1'b0}, t, ok);
    chk("ack", 1, ok);
    foreach (q[i]) mdl(8'(a + i), q[i]);
    repeat (20) @(posedge ref_clk);
  endtask
  // Full period window, so the count is phase independent
  task automatic meas();
    logic [31:0] c[`LPWM_NCH];
    int dv;
    dv = frq ? `LPWM_SLOW_DIV : `LPWM_FAST_DIV;
    foreach (c[i]) c[i] = 0;
    repeat (256 * dv) begin
      @(negedge ref_clk);
      foreach (c[i]) c[i] += led[i];
    end
    foreach (c[i]) begin
      chk("led", (soft_shutdown_n && !gdis && hw_shutdown_n && asc[i] >= 16) ? adu[i] * dv : 0, c[i]);
      chk("frac", num(asc[i]), frac[i]);
    end
    $display("test %0d done", ++tn);
  endtask
  initial begin
    logic [7:0] q[$];
    logic ok;
    void'($urandom(61225));
    strap <= 2'($urandom);
    mdl(8'h2F, 0);
    // Long enough for four link edges as well
    repeat (32) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge link_clk);
    meas();
    wr(8'h00, {8'h01});
    for (int i = 0; i < 18; i++) begin
      q[i] = 8'((i < 13 ? cd[i] : i == 13 ? $urandom % 16 : cd[$urandom % 13]) | ($urandom & 8'hC0));
    end
    wr(8'h14, q);
    for (int i = 0; i < 18; i++) q[i] = 8'(i == 0 ? 0 : i == 1 ? 255 : $urandom);
    wr(8'h01, q);
    wr(8'h13, {8'h01});
    meas();
    wr(8'h13, {8'h00});
    meas();
    wr(8'h26, {8'h01});
    meas();
    wr(8'h26, {8'h00});
    wr(8'h00, {8'h00});
    meas();
    wr(8'h00, {8'h01});
    hw_shutdown_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    meas();
    hw_shutdown_n <= 1'b1;
    wr(8'h27, {8'h01, 8'hFF});
    wr(8'h2E, {8'hA5, 8'h01});
    meas();
    wr(8'h27, {8'h00});
    u_lpwm_i2c_host.wr({`LPWM_DEV_ID_HI, ~strap, 1'b0}, {8'h00, 8'h00}, ok);
    chk("nack", 0, ok);
    wr(8'h2F, {8'h00});
    wr(8'h13, {8'h00});
    meas();
    summarize();
  end
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule
bind lpwm_top lpwm_top_sva u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap), .hw_shutdown_n(hw_shutdown_n),
  .led_outputs(led_outputs), .max_current_frac(max_current_frac));
`default_nettype wire
